// *** src/skip_branch_complement_ops.sv ***
/*
 * execute stage for complement, decrement/increment skip and unconditional jump.
 * decodes the instruction through the decoder module, forms the strobes for the
 * working register, the file register, the zero flag and the program counter,
 * and keeps the one-bit discard memory that turns the prefetched instruction
 * after a taken skip or a jump into a nop cycle.
 * every output is a register that stands for the cycle after the taking edge;
 * result data holds until the next taken instruction.
 * assumes fetch presents one instruction per instruction-cycle enable, with the
 * file register value already read, and acts on flush and pc_load the next cycle.
 * assumes the core applies each write strobe in the cycle in which it stands,
 * and holds instr_valid low while it has nothing to execute; idle cycles do not
 * end a pending discard.
 */
`timescale 1ns/10ps
`default_nettype none
module skip_branch_complement_ops (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	// instruction from fetch
	input  wire logic                        instr_valid,
	input  wire logic [sbc_pkg::INSTR_W-1:0] instr,
	input  wire logic [sbc_pkg::DATA_W-1:0]  file_data,
	input  wire logic [7:0]                  pc_page_latch,
	// working register write
	output logic                             w_write,
	output logic [sbc_pkg::DATA_W-1:0]       w_data,
	// file register write
	output logic                             f_write,
	output logic [sbc_pkg::FADDR_W-1:0]      f_addr,
	output logic [sbc_pkg::DATA_W-1:0]       f_data,
	// zero flag update
	output logic                             z_write,
	output logic                             z_value,
	// program flow
	output logic                             pc_load,
	output logic [sbc_pkg::PC_W-1:0]         pc_target,
	output logic                             flush,
	output logic                             nop_cycle
);
	// two states only: execute normally, or drop the next valid word
	typedef enum logic {EXEC, DISCARD} state_t;

	state_t state;
	state_t next_state;

	sbc_decode_if dec ();

	// operands straight from fetch, same clock, no synchroniser
	assign dec.instr      = instr;
	assign dec.file_data  = file_data;
	assign dec.page_latch = pc_page_latch;

	// pure decode and arithmetic, no state
	sbc_decoder sbc_decoder_inst (
		.dec (dec.decoder)
	);

	// state qualifiers
	wire exec_state    = (state == EXEC);
	wire discard_state = (state == DISCARD);

	// an instruction arriving during the discard cycle is the flushed prefetch
	wire take          = instr_valid && exec_state;
	wire dropped       = instr_valid && discard_state;

	// operation classes
	wire is_skip_op    = dec.is_dec_skip || dec.is_inc_skip;
	wire is_arith_op   = dec.is_complement || is_skip_op;
	wire to_working    = (dec.dest_file == sbc_pkg::DEST_W);

	// strobes for the cycle after the taking edge
	wire do_arith      = take && is_arith_op;
	wire do_skip       = take && is_skip_op && dec.result_zero;
	wire do_jump       = take && dec.is_jump;
	wire next_w        = do_arith && to_working;
	wire next_f        = do_arith && !to_working;
	// skips leave the zero flag alone, only the complement loads it
	wire next_z        = take && dec.is_complement;
	wire next_pc_load  = do_jump;
	wire next_flush    = do_skip || do_jump;
	wire next_nop      = dropped;

	// discard is armed by a flush and ended only by a valid word, never by idle
	wire enter_discard = next_flush;
	wire leave_discard = dropped;

	// result registers follow every taken instruction and hold otherwise
	wire [sbc_pkg::DATA_W-1:0]  next_w_data    = take ? dec.result : w_data;
	wire [sbc_pkg::FADDR_W-1:0] next_f_addr    = take ? instr[sbc_pkg::FADDR_W-1:0] : f_addr;
	wire [sbc_pkg::DATA_W-1:0]  next_f_data    = take ? dec.result : f_data;
	wire                        next_z_value   = take ? dec.result_zero : z_value;
	wire [sbc_pkg::PC_W-1:0]    next_pc_target = take ? dec.jump_target : pc_target;

	always_comb begin
		next_state = state;
		unique case (state)
			// a taken skip or jump arms the discard
			EXEC: begin
				if (enter_discard) begin
					next_state = DISCARD;
				end
			end
			// waits through idle cycles for the prefetched word, then drops it
			DISCARD: begin
				if (leave_discard) begin
					next_state = EXEC;
				end
			end
		endcase
	end

	// discard state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= EXEC;
		end else begin
			state <= next_state;
		end
	end

	// working register write strobe
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			w_write <= 1'b0;
		end else begin
			w_write <= next_w;
		end
	end

	// file register write strobe
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			f_write <= 1'b0;
		end else begin
			f_write <= next_f;
		end
	end

	// zero flag load strobe, complement only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			z_write <= 1'b0;
		end else begin
			z_write <= next_z;
		end
	end

	// program counter load strobe
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pc_load <= 1'b0;
		end else begin
			pc_load <= next_pc_load;
		end
	end

	// flush of the prefetched word
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			flush <= 1'b0;
		end else begin
			flush <= next_flush;
		end
	end

	// marks the cycle in which a dropped word ran as a nop
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			nop_cycle <= 1'b0;
		end else begin
			nop_cycle <= next_nop;
		end
	end

	// working register data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			w_data <= sbc_pkg::DATA_ZERO;
		end else begin
			w_data <= next_w_data;
		end
	end

	// file register address
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			f_addr <= '0;
		end else begin
			f_addr <= next_f_addr;
		end
	end

	// file register data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			f_data <= sbc_pkg::DATA_ZERO;
		end else begin
			f_data <= next_f_data;
		end
	end

	// zero flag value
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			z_value <= 1'b0;
		end else begin
			z_value <= next_z_value;
		end
	end

	// program counter target
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pc_target <= sbc_pkg::PC_RESET;
		end else begin
			pc_target <= next_pc_target;
		end
	end
endmodule
`default_nettype wire

// *** src/sbc_pkg.sv ***
/*
 * constants for the complement, skip and jump execute block.
 * assumes a 14-bit instruction word, 8-bit data path and 13-bit program counter.
 */
// Operation
// - opcode 001001 complements the file register, writes destination, updates zero flag
// - destination bit 0 writes working register, 1 writes back to file register
// - opcode 001011 decrements file register into destination, status flags untouched
// - zero result of decrement/increment skip discards fetched instruction, runs a nop
// - opcode 001111 increments file register into destination, skips on zero, no flags
// - skip instructions are one word, one cycle, or two when skipping
// - jump 101 loads pc 10:0 from immediate, upper bits from page latch 4:3
package sbc_pkg;
	localparam int INSTR_W     = 14;
	localparam int DATA_W      = 8;
	localparam int PC_W        = 13;
	localparam int FADDR_W     = 7;
	localparam int OP6_MSB     = 13;
	localparam int OP6_LSB     = 8;
	localparam int OP3_LSB     = 11;
	localparam int DEST_BIT    = 7;
	localparam int JUMP_K_W    = 11;
	localparam int PAGE_MSB    = 4;
	localparam int PAGE_LSB    = 3;
	localparam logic [5:0] OP_COMPLEMENT = 6'h09;
	localparam logic [5:0] OP_DEC_SKIP   = 6'h0b;
	localparam logic [5:0] OP_INC_SKIP   = 6'h0f;
	localparam logic [2:0] OP_JUMP       = 3'h5;
	localparam logic       DEST_W        = 1'h0;
	localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
endpackage

// *** src/sbc_decode_if.sv ***
/*
 * carries instruction, operands and decoded results between the core and its decoder.
 * assumes both ends share the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface sbc_decode_if;
	logic [sbc_pkg::INSTR_W-1:0] instr;
	logic [sbc_pkg::DATA_W-1:0]  file_data;
	logic [7:0]                  page_latch;
	logic                        is_complement;
	logic                        is_dec_skip;
	logic                        is_inc_skip;
	logic                        is_jump;
	logic                        dest_file;
	logic [sbc_pkg::DATA_W-1:0]  result;
	logic                        result_zero;
	logic [sbc_pkg::PC_W-1:0]    jump_target;

	modport decoder (
		input  instr, file_data, page_latch,
		output is_complement, is_dec_skip, is_inc_skip, is_jump, dest_file, result, result_zero, jump_target
	);
	modport core (
		output instr, file_data, page_latch,
		input  is_complement, is_dec_skip, is_inc_skip, is_jump, dest_file, result, result_zero, jump_target
	);
endinterface
`default_nettype wire

// *** src/sbc_decoder.sv ***
/*
 * combinational decode and arithmetic for the four instructions.
 * assumes operands are stable for the cycle in which the core samples the results.
 */
`timescale 1ns/10ps
`default_nettype none
module sbc_decoder (
	sbc_decode_if.decoder dec
);
	wire [5:0] op6 = dec.instr[sbc_pkg::OP6_MSB:sbc_pkg::OP6_LSB];
	wire [2:0] op3 = dec.instr[sbc_pkg::OP6_MSB:sbc_pkg::OP3_LSB];
	wire [sbc_pkg::DATA_W-1:0] inverted    = ~dec.file_data;
	wire [sbc_pkg::DATA_W-1:0] decremented = dec.file_data - sbc_pkg::DATA_ONE;
	wire [sbc_pkg::DATA_W-1:0] incremented = dec.file_data + sbc_pkg::DATA_ONE;

	assign dec.is_complement = (op6 == sbc_pkg::OP_COMPLEMENT);
	assign dec.is_dec_skip   = (op6 == sbc_pkg::OP_DEC_SKIP);
	assign dec.is_inc_skip   = (op6 == sbc_pkg::OP_INC_SKIP);
	assign dec.is_jump       = (op3 == sbc_pkg::OP_JUMP);
	assign dec.dest_file     = dec.instr[sbc_pkg::DEST_BIT];
	assign dec.result        = dec.is_complement ? inverted :
		dec.is_dec_skip ? decremented : incremented;
	assign dec.result_zero   = (dec.result == sbc_pkg::DATA_ZERO);
	// page bits 4:3 land in pc 12:11, immediate in pc 10:0
	assign dec.jump_target   = {dec.page_latch[sbc_pkg::PAGE_MSB:sbc_pkg::PAGE_LSB],
		dec.instr[sbc_pkg::JUMP_K_W-1:0]};
endmodule
`default_nettype wire

// *** verification/sbc_properties.sv ***
/* assertions for the skip, jump and complement execute block.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module sbc_properties (
	input wire logic                        clock, sys_rst, instr_valid,
	input wire logic [sbc_pkg::INSTR_W-1:0] instr,
	input wire logic [7:0]                  file_data, pc_page_latch, w_data, f_data,
	input wire logic [6:0]                  f_addr,
	input wire logic [12:0]                 pc_target,
	input wire logic                        w_write, f_write, z_write, z_value, pc_load, flush, nop_cycle
);
	logic hold;
	wire  drop = flush | hold;
	wire  take = instr_valid & ~drop;
	wire  is_c = take & instr[13:8] == sbc_pkg::OP_COMPLEMENT;
	wire  is_d = take & instr[13:8] == sbc_pkg::OP_DEC_SKIP;
	wire  is_i = take & instr[13:8] == sbc_pkg::OP_INC_SKIP;
	wire  is_j = take & instr[13:11] == sbc_pkg::OP_JUMP;
	wire  hit  = is_d & file_data == 8'h01 | is_i & file_data == 8'hff;
	wire  [7:0] res = w_write ? w_data : f_data;
	// discard window survives idle cycles
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst) hold <= 1'b0;
		else hold <= drop & ~instr_valid;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_quiet;
		!w_write && !f_write && !z_write && !pc_load && !flush;
	endsequence
	a_comp_zero: assert property (is_c |=> z_write && z_value == ($past(file_data) == 8'hff))
		else $error("complement zero flag wrong");
	a_comp_invert: assert property (is_c |=> res == ~$past(file_data))
		else $error("complement result wrong");
	a_dest_select: assert property (is_c | is_d | is_i |=> f_write == $past(instr[7]) && w_write != f_write
		&& (!f_write || f_addr == $past(instr[6:0]))) else $error("destination wrong");
	a_dec_value: assert property (is_d |=> !z_write && res == $past(file_data) - 8'h01)
		else $error("decrement result wrong");
	a_inc_value: assert property (is_i |=> !z_write && res == $past(file_data) + 8'h01)
		else $error("increment result wrong");
	a_skip_flush: assert property (is_d | is_i |=> flush == $past(hit))
		else $error("skip flush wrong");
	a_drop_nop: assert property (drop && instr_valid |=> nop_cycle ##0 s_quiet)
		else $error("dropped instruction not a nop");
	a_jump_load: assert property (is_j |=> pc_load && flush && !z_write
		&& pc_target == {$past(pc_page_latch[4:3]), $past(instr[10:0])}) else $error("jump target wrong");
	a_idle_quiet: assert property (!take |=> s_quiet)
		else $error("pulse without instruction");
endmodule
`default_nettype wire

// *** verification/skip_branch_complement_ops_tb.sv ***
/* random instruction stream bench with queued expectations.
   assumes results appear one cycle after each taken instruction. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t %h %h", $time, g, e); end end
module skip_branch_complement_ops_tb;
	logic        clock = 0, sys_rst = 1, instr_valid = 0, drop = 0;
	logic        w_write, f_write, z_write, z_value, pc_load, flush, nop_cycle;
	logic [13:0] instr = 0;
	logic [7:0]  file_data = 0, pc_page_latch = 0, w_data, f_data;
	logic [6:0]  f_addr;
	logic [12:0] pc_target;
	logic [19:0] q[$], got, want;
	logic [5:0]  ops[5] = '{sbc_pkg::OP_COMPLEMENT, sbc_pkg::OP_DEC_SKIP, sbc_pkg::OP_INC_SKIP, 6'h0a, 6'h0a};
	integer      seed = 32'heef26f39;
	int          n_mismatch = 0, checks = 0;
	always #5 clock = ~clock;
	skip_branch_complement_ops skip_branch_complement_ops_inst (.*);
	// note layout: write w, write f, zero load, zero value, pc load, nop, flush, data
	task automatic give(input logic [13:0] i, input logic [7:0] d);
		logic [7:0] r;
		logic       cz;
		@(posedge clock);
		#1;
		r = i[13:8] == sbc_pkg::OP_COMPLEMENT ? ~d : i[13:8] == sbc_pkg::OP_DEC_SKIP ? d - 8'h01 : d + 8'h01;
		cz = i[13:8] == sbc_pkg::OP_COMPLEMENT;
		instr_valid = 1;
		instr = i;
		file_data = d;
		pc_page_latch = $random(seed);
		if (drop) begin
			q.push_back(20'h04000);
			drop = 0;
		end else if (i[13:11] == sbc_pkg::OP_JUMP) begin
			q.push_back({7'b0000101, pc_page_latch[4:3], i[10:0]});
			drop = 1;
		end else if (i[13:8] != 6'h0a) begin
			drop = i[13:8] != sbc_pkg::OP_COMPLEMENT && r == 8'h00;
			q.push_back({~i[7], i[7], cz, cz && r == 8'h00, 2'b00, drop, 5'h00, r});
		end
	endtask
	always @(posedge clock) begin
		#2;
		if (w_write | f_write | z_write | pc_load | nop_cycle | flush) begin
			got = {w_write, f_write, z_write, z_write & z_value, pc_load, nop_cycle, flush,
				pc_load ? pc_target : w_write ? {5'h00, w_data} : f_write ? {5'h00, f_data} : 13'h0000};
			want = q.size() ? q.pop_front() : 20'h00000;
			`CHK(got, want)
		end
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		logic [13:0] i;
		logic [7:0] d;
		repeat (2) @(posedge clock);
		#1 sys_rst = 0;
		repeat (400) begin
			i = $random(seed);
			d = $random(seed);
			if (i[7:5] == 3'h0) i[13:11] = sbc_pkg::OP_JUMP;
			else i[13:8] = ops[{$random(seed)} % 5];
			if (d[7:5] == 3'h0) d = d[0] ? 8'hff : 8'h01;
			give(i, d);
			if (d[3] & d[2]) begin
				@(posedge clock);
				#1 instr_valid = 0;
			end
		end
		@(posedge clock);
		#1 instr_valid = 0;
		for (int n = 0; n < 10 && q.size() != 0; n++) @(posedge clock);
		if (q.size() != 0) n_mismatch++;
		$display("random stream test done");
		report_and_stop();
	end
endmodule
bind skip_branch_complement_ops sbc_properties sbc_properties_inst (.*);
`default_nettype wire
